// File: design/valve_pkg.sv
/*
 * Shared constants and types for the needle valve stepper control.
 * Assumes a 100 MHz system clock and a 12-bit analog sample on the same clock.
 */
package valve_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and motion figures
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned USTEPS_PER_STEP = 16;          // 1/16 microstepping
   localparam int unsigned FULL_RATE_X10   = 9918;        // 991.8 full steps/s
   localparam int unsigned TRAVEL_USTEPS   = 25500;       // Closed to open
   localparam int unsigned POS_W           = 15;
   // Phase increment per cycle at full speed, 32-bit accumulator
   localparam longint unsigned STEP_INC_FULL =
      (64'(USTEPS_PER_STEP) * 64'(FULL_RATE_X10) * 64'h1_0000_0000)
      / (64'(CLK_HZ) * 64'd10);

   ////////////////////////////////////////////////////////////////////////////
   // Analog and command scaling
   localparam int unsigned ADC_W          = 12;
   localparam int unsigned ADC_FULL       = 4095;
   localparam int unsigned DEADBAND_TENTH = 4;            // 0.4 % of full scale
   localparam logic [11:0] DEADBAND_RST   = 12'(ADC_FULL * DEADBAND_TENTH / 1000);
   localparam int unsigned CMD_FULL       = 10000;        // 100.00 % in 0.01 %
   localparam int unsigned CMD_W          = 14;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_TARGET   = 8'h04;
   localparam logic [7:0] REG_DEADBAND = 8'h08;
   localparam logic [7:0] REG_STATUS   = 8'h0c;
   localparam logic [7:0] REG_POSITION = 8'h10;
   localparam logic [13:0] TARGET_RST  = 14'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Operating modes and sequencer states
   typedef enum logic [1:0] {
      MODE_ANALOG_POS      = 2'h0,
      MODE_SERIAL_POSITION = 2'h1,
      MODE_DIR_SPEED       = 2'h2,
      MODE_STEP_DIR        = 2'h3
   } mode_type;
   localparam mode_type MODE_RST = MODE_ANALOG_POS;

   typedef enum logic [1:0] {
      ST_HOMING = 2'b01,
      ST_RUN    = 2'b10
   } state_type;

   // Pin inputs travelling together
   typedef struct packed {
      logic step_n;
      logic dir;
      logic close_n;
      logic open_n;
   } pins_type;
   localparam pins_type PINS_IDLE = '{step_n: 1'b1, dir: 1'b1, close_n: 1'b1, open_n: 1'b1};

endpackage

// File: design/microstep_rate_gen.sv
/*
 * Phase accumulator that issues one-cycle microstep enables at a rate
 * proportional to a 12-bit speed value; full value gives full speed.
 * Assumes rate comes from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module microstep_rate_gen
   import valve_pkg::*;
#(
   parameter logic [31:0] STEP_INC = 32'(STEP_INC_FULL)
) (
   input  wire logic              hclk,    // System clock
   input  wire logic              hresetn, // Async reset, active low
   input  wire logic [ADC_W-1:0]  rate,    // Speed, 0 to full scale
   output logic                   tick     // One microstep enable
);

   logic [31:0] acc_q;
   logic [32:0] sum;
   logic [43:0] prod;
   logic [31:0] inc;

   ////////////////////////////////////////////////////////////////////////////
   // Scale the increment linearly with rate
   assign prod = 44'(rate) * 44'(STEP_INC);
   assign inc  = 32'(prod / 44'(ADC_FULL));
   assign sum  = {1'b0, acc_q} + {1'b0, inc};

   // Accumulate, carry marks one microstep
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_q <= 32'h0000_0000;
         tick  <= 1'b0;
      end else begin
         acc_q <= sum[31:0];
         tick  <= sum[32];
      end
   end

endmodule
`default_nettype wire

// File: design/valve_stepper_control.sv
/*
 * Needle valve stepper control: mode selection, position and speed
 * targets, overrides, power-up homing and an AHB-Lite register slave.
 * Assumes asynchronous pin inputs, an ADC sample stream on hclk and
 * an AHB-Lite master on the same clock.
 */
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Direction low closes, high opens.
// - Each step falling edge moves one microstep.
// - Motor runs sixteen microsteps per full step.
// - Full travel spans 25500 microsteps.
// - Analog position target linear in input.
// - Analog below dead band commands closed.
// - Speed below dead band gives no motion.
// - Serial command 0.00 to 100.00 percent.
// - Speed linear in analog input.
// - Full speed is 991.8 full steps/s.
// - Exactly four modes, one active.
// - Close override closes, shows green.
// - Open override opens, shows steady red.
// - Released override resumes active mode.
// - Power-up homes closed, then runs mode.
// - Step ignored outside step mode, direction outside step and speed modes.
module valve_stepper_control
   import valve_pkg::*;
#(
   parameter logic [31:0] STEP_INC = 32'(STEP_INC_FULL)  // Full-speed increment
) (
   input  wire logic              hclk,        // System clock, 100 MHz
   input  wire logic              hresetn,     // Async reset, active low
   // AHB-Lite slave
   input  wire logic              hsel,        // Slave select
   input  wire logic [31:0]       haddr,       // Address
   input  wire logic [1:0]        htrans,      // Transfer type
   input  wire logic              hwrite,      // Write when high
   input  wire logic [2:0]        hsize,       // Transfer size
   input  wire logic [31:0]       hwdata,      // Write data
   input  wire logic              hready,      // Bus ready in
   output logic                   hreadyout,   // Always ready
   output logic                   hresp,       // Always OKAY
   output logic [31:0]            hrdata,      // Read data
   // Valve pins, asynchronous
   input  wire logic              step_in_n,   // Step clock, falling edge
   input  wire logic              dir_in,      // Direction, high opens
   input  wire logic              close_ovr_n, // Close override, low active
   input  wire logic              open_ovr_n,  // Open override, low active
   // Analog sample, same clock
   input  wire logic [ADC_W-1:0]  adc_data,    // Digitized analog input
   // Motor and indicator
   output logic                   motor_step,  // One pulse per microstep
   output logic                   motor_dir,   // High toward open
   output logic [POS_W-1:0]       position,    // Microstep position
   output logic                   led_green,   // Closed indicator
   output logic                   led_red      // Open indicator
);

   ////////////////////////////////////////////////////////////////////////////
   // Scaling helpers
   function automatic logic [POS_W-1:0] scale_pos(input logic [31:0] v,
                                                  input logic [31:0] full);
      logic [31:0] p;
      p = (v * 32'(TRAVEL_USTEPS)) / full;
      return POS_W'(p);
   endfunction

   localparam logic [POS_W-1:0] POS_OPEN = POS_W'(TRAVEL_USTEPS);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   pins_type              pins_raw;
   pins_type              meta_q;
   pins_type              sync_q;
   logic                  step_prev_q;
   logic [ADC_W-1:0]      adc_q;
   mode_type              mode_q;
   logic [CMD_W-1:0]      target_q;
   logic [ADC_W-1:0]      deadband_q;
   state_type             state_q;
   state_type             state_d;
   logic [POS_W-1:0]      pos_q;
   logic [POS_W-1:0]      pos_d;
   logic                  mstep_q;
   logic                  mdir_q;
   logic                  wr_pend_q;
   logic [7:0]            wr_addr_q;
   logic [31:0]           rdata_q;

   logic                  bus_take;
   logic                  bus_wr;
   logic [31:0]           rd_mux;
   logic [CMD_W-1:0]      cmd_clamped;
   logic                  close_act;
   logic                  open_act;
   logic                  step_edge;
   logic                  adc_quiet;
   logic [POS_W-1:0]      analog_target;
   logic [POS_W-1:0]      serial_target;
   logic [POS_W-1:0]      target;
   logic                  seek_mode;
   logic [ADC_W-1:0]      rate;
   logic                  rate_tick;
   logic                  want_up;
   logic                  want_dn;
   logic                  go_up;
   logic                  go_dn;
   logic                  at_closed;
   logic                  at_open;
   logic                  wr_ctrl;
   logic                  wr_target;
   logic                  wr_deadband;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two flops each
   assign pins_raw = '{step_n: step_in_n, dir: dir_in,
                       close_n: close_ovr_n, open_n: open_ovr_n};

   // Reset to idle pin levels, so no false step edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q      <= PINS_IDLE;
         sync_q      <= PINS_IDLE;
         step_prev_q <= 1'b1;
      end else begin
         meta_q      <= pins_raw;
         sync_q      <= meta_q;
         step_prev_q <= sync_q.step_n;
      end
   end

   // Sample register for the analog value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         adc_q <= '0;
      end else begin
         adc_q <= adc_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite decode: zero wait, always OKAY
   assign bus_take    = hsel & htrans[1] & hready;
   assign bus_wr      = bus_take & hwrite;
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign hrdata      = rdata_q;
   assign cmd_clamped = (hwdata[31:0] > 32'(CMD_FULL)) ? CMD_W'(CMD_FULL)
                                                       : hwdata[CMD_W-1:0];

   // Read mux: status shows homing, overrides and direction
   assign rd_mux =
      (haddr[7:0] == REG_CTRL)     ? {30'h0000_0000, mode_q} :
      (haddr[7:0] == REG_TARGET)   ? {18'h0_0000, target_q} :
      (haddr[7:0] == REG_DEADBAND) ? {20'h0_0000, deadband_q} :
      (haddr[7:0] == REG_STATUS)   ? {28'h000_0000, mdir_q, open_act,
                                      close_act, state_q == ST_HOMING} :
      (haddr[7:0] == REG_POSITION) ? {17'h0_0000, pos_q} :
                                     32'h0000_0000;

   // Write strobes for the data phase
   assign wr_ctrl     = wr_pend_q & (wr_addr_q == REG_CTRL);
   assign wr_target   = wr_pend_q & (wr_addr_q == REG_TARGET);
   assign wr_deadband = wr_pend_q & (wr_addr_q == REG_DEADBAND);

   // Address phase capture and read data
   // Read data are latched in the address phase, so a read
   // straight after a write to the same register sees the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q   <= 32'h0000_0000;
      end else begin
         wr_pend_q <= bus_wr;
         if (bus_take) begin
            wr_addr_q <= haddr[7:0];
         end
         if (bus_take && !hwrite) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Register writes in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q     <= MODE_RST;
         target_q   <= TARGET_RST;
         deadband_q <= DEADBAND_RST;
      end else begin
         if (wr_ctrl) begin
            mode_q <= mode_type'(hwdata[1:0]);
         end
         if (wr_target) begin
            target_q <= cmd_clamped;
         end
         if (wr_deadband) begin
            deadband_q <= hwdata[ADC_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overrides: low level asserts, close wins over open
   // Released or floating pins read high, so no override
   assign close_act = ~sync_q.close_n;
   assign open_act  = ~sync_q.open_n & ~close_act;

   // Falling edge of step input, only used in step mode
   assign step_edge = step_prev_q & ~sync_q.step_n;

   ////////////////////////////////////////////////////////////////////////////
   // Targets for the position modes
   // Dead band gates both the position and the speed use
   assign adc_quiet     = adc_q < deadband_q;
   assign analog_target = adc_quiet ? '0
                        : scale_pos(32'(adc_q), 32'(ADC_FULL));
   assign serial_target = scale_pos(32'(target_q), 32'(CMD_FULL));

   // Target seen by the seek logic; overrides take the ends of travel
   assign target = close_act                  ? '0 :
                   open_act                   ? POS_OPEN :
                   (mode_q == MODE_SERIAL_POSITION) ? serial_target
                                              : analog_target;

   // Seek toward a target unless direction-driven mode runs freely
   assign seek_mode = close_act | open_act |
                      (mode_q == MODE_ANALOG_POS) |
                      (mode_q == MODE_SERIAL_POSITION);

   ////////////////////////////////////////////////////////////////////////////
   // Rate selection: speed input only in direction/speed mode
   // Homing and overrides always seek at full rate
   assign rate = (state_q == ST_RUN && !seek_mode && mode_q == MODE_DIR_SPEED)
               ? (adc_quiet ? '0 : adc_q)
               : ADC_W'(ADC_FULL);

   // Microstep rate, full value gives 991.8 full steps per second
   microstep_rate_gen #(
      .STEP_INC (STEP_INC)
   ) u_rate (
      .hclk    (hclk),
      .hresetn (hresetn),
      .rate    (rate),
      .tick    (rate_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Motion requests per state and mode
   always_comb begin
      want_up = 1'b0;
      want_dn = 1'b0;
      case (state_q)
         ST_HOMING: begin
            want_dn = rate_tick;
         end
         ST_RUN: begin
            if (seek_mode) begin
               want_up = rate_tick & (pos_q < target);
               want_dn = rate_tick & (pos_q > target);
            end else if (mode_q == MODE_DIR_SPEED) begin
               want_up = rate_tick & sync_q.dir;
               want_dn = rate_tick & ~sync_q.dir;
            end else begin
               want_up = step_edge & sync_q.dir;
               want_dn = step_edge & ~sync_q.dir;
            end
         end
         default: begin
            want_up = 1'b0;
            want_dn = 1'b0;
         end
      endcase
   end

   // Clamp at both ends of travel
   // Requests past either end are dropped, never queued
   assign at_closed = pos_q == '0;
   assign at_open   = pos_q >= POS_OPEN;
   assign go_up     = want_up & ~at_open;
   assign go_dn     = want_dn & ~at_closed;
   assign pos_d     = go_up ? pos_q + POS_W'(1) :
                      go_dn ? pos_q - POS_W'(1) : pos_q;

   // Homing ends once the closed end is reached
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_HOMING: begin
            if (at_closed) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_HOMING;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Position, state and motor outputs
   // Position unknown at power-up: assume open, step down
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_HOMING;
         pos_q   <= POS_OPEN;
         mstep_q <= 1'b0;
         mdir_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         pos_q   <= pos_d;
         mstep_q <= go_up | go_dn;
         if (go_up | go_dn) begin
            mdir_q <= go_up;
         end
      end
   end

   assign motor_step = mstep_q;
   assign motor_dir  = mdir_q;
   assign position   = pos_q;

   // Indicator follows the active override
   // Lamps follow the synchronised pins, not the position
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         led_green <= 1'b0;
         led_red   <= 1'b0;
      end else begin
         led_green <= close_act;
         led_red   <= open_act;
      end
   end

endmodule
`default_nettype wire

// File: verif/valve_stepper_control_properties.sv
/* Port checker for the needle valve control.
   Assumes it is bound to valve_stepper_control and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module valve_stepper_control_chk
   import valve_pkg::*;
#(
   parameter logic [31:0] STEP_INC = 32'(STEP_INC_FULL) // Rate increment
) (
   input wire logic             hclk,        // Clock
   input wire logic             hresetn,     // Reset, active low
   input wire logic             close_ovr_n, // Close override
   input wire logic             open_ovr_n,  // Open override
   input wire logic             motor_step,  // Step pulse
   input wire logic             motor_dir,   // Step direction
   input wire logic [POS_W-1:0] position,    // Microstep position
   input wire logic             led_green,   // Closed lamp
   input wire logic             led_red      // Open lamp
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////
   // Motion
   property p_step_moves;
      motor_step |-> position == (motor_dir ? $past(position) + 15'd1
                                            : $past(position) - 15'd1);
   endproperty
   a_step_moves: assert property (p_step_moves)
      else $error("step pulse without one microstep of motion");
   property p_pos_clamp;
      position <= 15'd25500;
   endproperty
   a_pos_clamp: assert property (p_pos_clamp)
      else $error("position beyond full travel");
   property p_home_start;
      $rose(hresetn) |-> ##[1:40] (motor_step && !motor_dir);
   endproperty
   a_home_start: assert property (p_home_start)
      else $error("no closing step after reset release");

   ////////////////////////////////////////////////////////////////////////
   // Overrides and indicator
   property p_close_led;
      (!close_ovr_n)[*5] |-> led_green && !led_red;
   endproperty
   a_close_led: assert property (p_close_led)
      else $error("close override without green lamp");
   property p_close_dir;
      (!close_ovr_n)[*6] ##0 motor_step |-> !motor_dir;
   endproperty
   a_close_dir: assert property (p_close_dir)
      else $error("opening step under close override");
   property p_open_led;
      (!open_ovr_n && close_ovr_n)[*5] |-> led_red && !led_green;
   endproperty
   a_open_led: assert property (p_open_led)
      else $error("open override without red lamp");
   property p_open_dir;
      (!open_ovr_n && close_ovr_n)[*6] ##0 motor_step |-> motor_dir;
   endproperty
   a_open_dir: assert property (p_open_dir)
      else $error("closing step under open override");
   property p_both_close;
      (!open_ovr_n && !close_ovr_n)[*5] |-> led_green && !led_red;
   endproperty
   a_both_close: assert property (p_both_close)
      else $error("open override beat close override");
   property p_release;
      (open_ovr_n && close_ovr_n)[*5] |-> !led_green && !led_red;
   endproperty
   a_release: assert property (p_release)
      else $error("lamp still lit after override release");

   // Main scenarios reached
   c_up: cover property (motor_step && motor_dir);
   c_green: cover property (led_green);
   c_red: cover property (led_red);
endmodule
bind valve_stepper_control valve_stepper_control_chk #(.STEP_INC(STEP_INC)) chk_i (
   .hclk(hclk), .hresetn(hresetn), .close_ovr_n(close_ovr_n), .open_ovr_n(open_ovr_n),
   .motor_step(motor_step), .motor_dir(motor_dir), .position(position),
   .led_green(led_green), .led_red(led_red));
`default_nettype wire

// File: verif/plc_model.sv
/* Model of the controller on the valve pins: step, direction and
   open-collector overrides. Assumes the bench calls its tasks. */
`timescale 1ns/100ps
`default_nettype none
module plc_model
   import valve_pkg::*;
(
   input  wire logic   hclk, // Clock
   output var pins_type pins // Pin levels
);
   // Lines idle high through their pull-ups
   initial pins = PINS_IDLE;

   // Direction level and override lines; released lines read high
   task automatic drive(input logic d, input logic close_on, input logic open_on);
      @(posedge hclk);
      pins.dir     <= d;
      pins.close_n <= !close_on;
      pins.open_n  <= !open_on;
   endtask

   // Step pulses, low and high each held w cycles, direction set first
   task automatic pulse(input logic d, input int n, input int w);
      @(posedge hclk);
      pins.dir <= d;
      repeat (4) @(posedge hclk);
      repeat (n) begin
         pins.step_n <= 1'b0;
         repeat (w) @(posedge hclk);
         pins.step_n <= 1'b1;
         repeat (w) @(posedge hclk);
      end
   endtask
endmodule
`default_nettype wire

// File: verif/valve_stepper_control_tb.sv
/* Self-checking bench: registers, homing, all four modes, overrides.
   Assumes the pin model and a fast rate increment, one step per two cycles. */
`timescale 1ns/100ps
`default_nettype none
module valve_stepper_control_tb
   import valve_pkg::*;
;
   localparam logic [31:0] SINC = 32'h8000_0000;
   logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]      haddr, hwdata, hrdata, seed, rd;
   logic [1:0]       htrans;
   logic [2:0]       hsize;
   logic [ADC_W-1:0] adc;
   logic             motor_step, motor_dir, led_green, led_red;
   logic [POS_W-1:0] position;
   pins_type         pins;
   int               failures, n_checks, cnt, p0, t, e;

   assign hready = hreadyout;
   valve_stepper_control #(.STEP_INC(SINC)) valve_stepper_control_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .step_in_n(pins.step_n), .dir_in(pins.dir), .close_ovr_n(pins.close_n),
      .open_ovr_n(pins.open_n), .adc_data(adc), .motor_step(motor_step),
      .motor_dir(motor_dir), .position(position), .led_green(led_green),
      .led_red(led_red));
   plc_model plc_model_i (.hclk(hclk), .pins(pins));

   // Clock and watchdog
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      repeat (90000) @(posedge hclk);
      failures++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected microstep target for a value on a given full scale
   function automatic int exp_pos(input int v, input int full);
      return v * int'(TRAVEL_USTEPS) / full;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (failures == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // One AHB-Lite single transfer, read data left in rd
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   // Wait for a position, let it settle, then compare
   task automatic wait_pos(input int exp);
      for (int i = 0; i < 60000 && position !== POS_W'(exp); i++) @(negedge hclk);
      repeat (20) @(negedge hclk);
      check(32'(position), 32'(exp));
   endtask
   task automatic count_steps(input int n);
      repeat (5) @(negedge hclk);
      p0  = int'(position);
      cnt = 0;
      repeat (n) begin
         @(negedge hclk);
         cnt += int'(motor_step);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      adc = 12'h000;
      seed = 32'h0000_0041;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, unmapped place, homing
      rdchk(REG_CTRL, 32'h0);
      rdchk(REG_TARGET, 32'h0);
      rdchk(REG_DEADBAND, 32'(DEADBAND_RST));
      rdchk(8'h20, 32'h0);
      check(32'(hresp), 32'h0);
      ahb(1'b0, REG_STATUS, 32'h0);
      check(32'(rd[0]), 32'h1);
      wait_pos(0);
      // Analog position: random levels, dead band edge, below it
      repeat (2) begin
         t = 100 + int'(rnd() % 128);
         @(posedge hclk);
         adc <= ADC_W'(t);
         wait_pos(exp_pos(t, ADC_FULL));
      end
      @(posedge hclk);
      adc <= 12'h010;
      wait_pos(exp_pos(16, ADC_FULL));
      @(posedge hclk);
      adc <= 12'h00f;
      wait_pos(0);
      // Raised dead band swallows a level that moved the needle
      @(posedge hclk);
      adc <= 12'h030;
      wait_pos(exp_pos(48, ADC_FULL));
      ahb(1'b1, REG_DEADBAND, 32'h40);
      rdchk(REG_DEADBAND, 32'h40);
      wait_pos(0);
      @(posedge hclk);
      adc <= 12'h000;
      ahb(1'b1, REG_DEADBAND, 32'(DEADBAND_RST));
      // Serial position: clamp, random target, step pins ignored
      ahb(1'b1, REG_CTRL, 32'h1);
      ahb(1'b1, REG_TARGET, 32'd12000);
      rdchk(REG_TARGET, 32'd10000);
      t = 40 + int'(rnd() % 512);
      e = exp_pos(t, CMD_FULL);
      ahb(1'b1, REG_TARGET, 32'(t));
      wait_pos(e);
      rdchk(REG_POSITION, 32'(e));
      plc_model_i.pulse(1'b1, 3, 3);
      wait_pos(e);
      // Overrides: open lifts, close wins, release resumes
      plc_model_i.drive(1'b1, 1'b0, 1'b1);
      repeat (60) @(negedge hclk);
      check(32'(position > POS_W'(e)), 32'h1);
      check(32'(led_red), 32'h1);
      ahb(1'b0, REG_STATUS, 32'h0);
      check(32'(rd[3:2]), 32'h3);
      plc_model_i.drive(1'b1, 1'b1, 1'b1);
      wait_pos(0);
      check(32'({led_green, led_red}), 32'h2);
      ahb(1'b0, REG_STATUS, 32'h0);
      check(32'(rd[1]), 32'h1);
      plc_model_i.drive(1'b1, 1'b0, 1'b0);
      wait_pos(e);
      // Step mode: clamp at closed, random count up, two down
      ahb(1'b1, REG_TARGET, 32'h0);
      wait_pos(0);
      ahb(1'b1, REG_CTRL, 32'h3);
      plc_model_i.pulse(1'b0, 2, 3);
      wait_pos(0);
      t = 3 + int'(rnd() % 8);
      plc_model_i.pulse(1'b1, t, 3 + int'(rnd() % 4));
      wait_pos(t);
      plc_model_i.pulse(1'b0, 2, 5);
      wait_pos(t - 2);
      // Speed mode: dead band, full rate up, half rate down
      ahb(1'b1, REG_CTRL, 32'h2);
      @(posedge hclk);
      adc <= 12'h00f;
      plc_model_i.pulse(1'b1, 3, 3);
      count_steps(100);
      check(32'(cnt), 32'h0);
      check(32'(position), 32'(t - 2));
      @(posedge hclk);
      adc <= 12'hfff;
      count_steps(400);
      check(32'(cnt >= 199 && cnt <= 201), 32'h1);
      check(32'(int'(position) - p0), 32'(cnt));
      plc_model_i.drive(1'b0, 1'b0, 1'b0);
      @(posedge hclk);
      adc <= 12'h800;
      count_steps(400);
      check(32'(cnt >= 98 && cnt <= 102), 32'h1);
      check(32'(p0 - int'(position)), 32'(cnt));
      end_of_test();
   end
endmodule
`default_nettype wire
